// >>> sdt_framer.sv
// serial digital audio transmitter: framing, flag bits and output pin
`default_nettype none
module sdt_framer (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // serial control port
    input wire logic ctl_cs_n,
    input wire logic ctl_sclk,
    input wire logic ctl_sdin,
    // half-cell timing
    input wire logic half_cell_tick,
    // audio sources
    input wire logic [23:0] rx_sample_left,
    input wire logic [23:0] rx_sample_right,
    input wire logic [23:0] adc_sample_left,
    input wire logic [23:0] adc_sample_right,
    input wire logic [23:0] aif2_sample_left,
    input wire logic [23:0] aif2_sample_right,
    input wire logic [23:0] aif1_sample_left,
    input wire logic [23:0] aif1_sample_right,
    // recovered flag bits from the receiver
    input wire logic rx_validity_left,
    input wire logic rx_validity_right,
    input wire logic rx_user_left,
    input wire logic rx_user_right,
    input wire logic rx_chan_status_left,
    input wire logic rx_chan_status_right,
    // raw input multiplexer signal
    input wire logic spdif_in_mux,
    // outputs
    output logic sample_take,
    output logic tx_running,
    output logic serial_audio_out_pin
);
    logic [8:0] tx_source_control;
    logic [8:0] cs1, cs2, cs3, cs4;
    logic [8:0] power_down_two;
    logic [1:0] tx_audio_source_sel;
    logic chan_status_override, through_mode, tx_power_down;

    sdt_ctl_port u_ctl (
        .clock(clock),
        .rst(rst),
        .ctl_cs_n(ctl_cs_n),
        .ctl_sclk(ctl_sclk),
        .ctl_sdin(ctl_sdin),
        .tx_source_control(tx_source_control),
        .chan_status_1(cs1),
        .chan_status_2(cs2),
        .chan_status_3(cs3),
        .chan_status_4(cs4),
        .power_down_two(power_down_two)
    );

    assign tx_audio_source_sel = tx_source_control[sdt_pkg::SRC_MSB:sdt_pkg::SRC_LSB];
    assign chan_status_override = tx_source_control[sdt_pkg::OVW_BIT];
    assign through_mode = tx_source_control[sdt_pkg::THRU_BIT];
    assign tx_power_down = power_down_two[sdt_pkg::TXPD_BIT];

    // sequencing state
    sdt_pkg::sdt_state_t state_reg, state_next;
    logic half_reg, half_next;
    logic [4:0] slot_reg, slot_next;
    logic sub_reg, sub_next;
    logic [7:0] frame_reg, frame_next;
    logic take_reg, take_next;
    logic run;
    logic tick;

    assign run = (state_reg == sdt_pkg::SDT_RUN);
    assign tick = run && half_cell_tick;

    always_comb
    begin
        state_next = state_reg;
        half_next = half_reg;
        slot_next = slot_reg;
        sub_next = sub_reg;
        frame_next = frame_reg;
        take_next = 1'b0;
        case (state_reg)
            sdt_pkg::SDT_IDLE:
            begin
                half_next = 1'b0;
                slot_next = 5'h00;
                sub_next = 1'b0;
                frame_next = 8'h00;
                if (!tx_power_down)
                    state_next = sdt_pkg::SDT_RUN;
            end
            sdt_pkg::SDT_RUN:
            begin
                if (tx_power_down)
                    state_next = sdt_pkg::SDT_IDLE;
                else if (half_cell_tick)
                begin
                    take_next = !half_reg && (slot_reg == 5'h00) && !sub_reg;
                    half_next = ~half_reg;
                    if (half_reg)
                    begin
                        slot_next = slot_reg + 5'h01;
                        if (slot_reg == sdt_pkg::SLOT_LAST)
                        begin
                            sub_next = ~sub_reg;
                            if (sub_reg)
                                frame_next = (frame_reg == sdt_pkg::FRAME_LAST) ?
                                    8'h00 : frame_reg + 8'h01;
                        end
                    end
                end
            end
            default:
                state_next = sdt_pkg::SDT_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= sdt_pkg::SDT_IDLE;
            half_reg <= 1'b0;
            slot_reg <= 5'h00;
            sub_reg <= 1'b0;
            frame_reg <= 8'h00;
            take_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            half_reg <= half_next;
            slot_reg <= slot_next;
            sub_reg <= sub_next;
            frame_reg <= frame_next;
            take_reg <= take_next;
        end
    end

    // per-frame sample and received flags, caught at the first half-cell
    logic [23:0] smp_reg [2];
    logic [23:0] smp_next [2];
    logic [1:0] rx_v_reg, rx_v_next;
    logic [1:0] rx_u_reg, rx_u_next;
    logic [1:0] rx_c_reg, rx_c_next;
    logic latch_now;

    assign latch_now = tick && !half_reg && (slot_reg == 5'h00) && !sub_reg;

    always_comb
    begin
        smp_next = smp_reg;
        rx_v_next = rx_v_reg;
        rx_u_next = rx_u_reg;
        rx_c_next = rx_c_reg;
        if (latch_now)
        begin
            case (tx_audio_source_sel)
                sdt_pkg::SRC_RX: smp_next = '{rx_sample_left, rx_sample_right};
                sdt_pkg::SRC_ADC: smp_next = '{adc_sample_left, adc_sample_right};
                sdt_pkg::SRC_AIF2: smp_next = '{aif2_sample_left, aif2_sample_right};
                default: smp_next = '{aif1_sample_left, aif1_sample_right};
            endcase
            rx_v_next = {rx_validity_right, rx_validity_left};
            rx_u_next = {rx_user_right, rx_user_left};
            rx_c_next = {rx_chan_status_right, rx_chan_status_left};
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            smp_reg <= '{24'h000000, 24'h000000};
            rx_v_reg <= 2'h0;
            rx_u_reg <= 2'h0;
            rx_c_reg <= 2'h0;
        end
        else
        begin
            smp_reg <= smp_next;
            rx_v_reg <= rx_v_next;
            rx_u_reg <= rx_u_next;
            rx_c_reg <= rx_c_next;
        end
    end

    // channel status words, one per sub-frame
    logic [3:0] chn_bits [2];
    logic [sdt_pkg::CS_USED_BITS-1:0] cs_word [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_cs
            logic [1:0] code;
            assign code = (g == 0) ? cs3[sdt_pkg::CHNUM1_LSB +: 2] : cs3[sdt_pkg::CHNUM2_LSB +: 2];
            assign chn_bits[g] = (code == sdt_pkg::CHNUM_LEFT) ? sdt_pkg::CHN_LEFT_BITS :
                (code == sdt_pkg::CHNUM_RIGHT) ? sdt_pkg::CHN_RIGHT_BITS : sdt_pkg::CHN_NONE_BITS;
            // only the channel number differs between the two words
            assign cs_word[g] = {10'h000, cs4[5:0], chn_bits[g], cs3[3:0], cs2[7:0],
                cs1[7:0]};
        end
    endgenerate

    // sub-frame bits
    logic from_rx;
    logic v_bit, u_bit, c_bit, p_bit;
    logic [23:0] cur_smp;
    logic [31:0] sub_word;
    logic data_bit;
    logic [7:0] pre_pattern;

    assign from_rx = (tx_audio_source_sel == sdt_pkg::SRC_RX);
    assign cur_smp = smp_reg[sub_reg];
    assign v_bit = from_rx ? rx_v_reg[sub_reg] : 1'b0;
    assign u_bit = from_rx ? rx_u_reg[sub_reg] : 1'b0;

    always_comb
    begin
        if (from_rx && !chan_status_override)
            c_bit = rx_c_reg[sub_reg];
        else if (frame_reg < sdt_pkg::CS_USED_FRAMES)
            c_bit = cs_word[sub_reg][frame_reg[5:0]];
        else
            c_bit = 1'b0;
    end

    assign p_bit = ^{cur_smp, v_bit, u_bit, c_bit};
    // 24-bit sample in slots 4-27, lsb first
    assign sub_word = {p_bit, c_bit, u_bit, v_bit, cur_smp, 4'h0};
    assign data_bit = sub_word[slot_reg];

    always_comb
    begin
        if (sub_reg)
            pre_pattern = sdt_pkg::PRE_SECOND;
        else if (frame_reg == 8'h00)
            pre_pattern = sdt_pkg::PRE_BLOCK;
        else
            pre_pattern = sdt_pkg::PRE_FIRST;
    end

    logic enc_line;

    sdt_bmc_enc u_enc (
        .clock(clock),
        .rst(rst),
        .run(run),
        .tick(tick),
        .pre_active(slot_reg <= sdt_pkg::SLOT_PRE_LAST),
        .pre_pattern(pre_pattern),
        .pre_half_idx({slot_reg[1:0], half_reg}),
        .data_bit(data_bit),
        .second_half(half_reg),
        .line(enc_line)
    );

    // output pin register
    logic pin_reg, pin_next;

    always_comb
    begin
        if (through_mode)
            pin_next = spdif_in_mux;
        else if (run)
            pin_next = enc_line;
        else
            pin_next = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            pin_reg <= 1'b0;
        else
            pin_reg <= pin_next;
    end

    assign serial_audio_out_pin = pin_reg;
    assign sample_take = take_reg;
    assign tx_running = run;
endmodule
`default_nettype wire

// >>> sdt_pkg.sv
// constants for the serial digital audio transmitter framer
`default_nettype none
package sdt_pkg;
    // control port word: address then data, msb first
    localparam int ADDR_W = 7;
    localparam int DATA_W = 9;
    localparam logic [4:0] WORD_BITS = 5'h10;

    // register addresses
    localparam logic [6:0] REG_TX_SOURCE_CONTROL = 7'h1E;
    localparam logic [6:0] REG_CHAN_STATUS_1 = 7'h1F;
    localparam logic [6:0] REG_CHAN_STATUS_2 = 7'h20;
    localparam logic [6:0] REG_CHAN_STATUS_3 = 7'h21;
    localparam logic [6:0] REG_CHAN_STATUS_4 = 7'h22;
    localparam logic [6:0] REG_POWER_DOWN_TWO = 7'h33;

    // register bank indices
    localparam int NUM_REGS = 6;
    localparam logic [2:0] IDX_SRC = 3'h0;
    localparam logic [2:0] IDX_CS1 = 3'h1;
    localparam logic [2:0] IDX_CS2 = 3'h2;
    localparam logic [2:0] IDX_CS3 = 3'h3;
    localparam logic [2:0] IDX_CS4 = 3'h4;
    localparam logic [2:0] IDX_PWR = 3'h5;
    localparam logic [2:0] IDX_NONE = 3'h7;

    // reset values, by index
    localparam logic [8:0] RST_VALS [NUM_REGS] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h031, 9'h010};

    // tx_source_control fields
    localparam int SRC_LSB = 0;
    localparam int SRC_MSB = 1;
    localparam int OVW_BIT = 2;
    localparam int THRU_BIT = 3;
    // power_down_two field
    localparam int TXPD_BIT = 4;

    // source select codes
    localparam logic [1:0] SRC_RX = 2'h0;
    localparam logic [1:0] SRC_ADC = 2'h1;
    localparam logic [1:0] SRC_AIF2 = 2'h2;
    localparam logic [1:0] SRC_AIF1 = 2'h3;

    // channel number codes and status field positions
    localparam logic [1:0] CHNUM_LEFT = 2'h1;
    localparam logic [1:0] CHNUM_RIGHT = 2'h2;
    localparam logic [3:0] CHN_LEFT_BITS = 4'h1;
    localparam logic [3:0] CHN_RIGHT_BITS = 4'h2;
    localparam logic [3:0] CHN_NONE_BITS = 4'h0;
    localparam int CHNUM1_LSB = 4;
    localparam int CHNUM2_LSB = 6;
    localparam int CS_USED_BITS = 40;

    // block and sub-frame layout
    localparam logic [7:0] FRAME_LAST = 8'hBF;
    localparam logic [7:0] CS_USED_FRAMES = 8'h28;
    localparam logic [4:0] SLOT_LAST = 5'h1F;
    localparam logic [4:0] SLOT_PRE_LAST = 5'h03;
    localparam int SLOT_V = 28;
    localparam int SLOT_U = 29;
    localparam int SLOT_C = 30;
    localparam int SLOT_P = 31;
    localparam int SAMPLE_W = 24;

    // preamble half-cell patterns, for a preceding line level of zero
    localparam logic [7:0] PRE_BLOCK = 8'hE8;
    localparam logic [7:0] PRE_FIRST = 8'hE2;
    localparam logic [7:0] PRE_SECOND = 8'hE4;

    typedef enum logic {SDT_IDLE, SDT_RUN} sdt_state_t;
endpackage
`default_nettype wire

// >>> sdt_ctl_port.sv
// three-wire serial control port and register bank
`default_nettype none
module sdt_ctl_port (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // serial control pins
    input wire logic ctl_cs_n,
    input wire logic ctl_sclk,
    input wire logic ctl_sdin,
    // register contents
    output logic [8:0] tx_source_control,
    output logic [8:0] chan_status_1,
    output logic [8:0] chan_status_2,
    output logic [8:0] chan_status_3,
    output logic [8:0] chan_status_4,
    output logic [8:0] power_down_two
);
    logic [15:0] shift_reg, shift_next;
    logic [4:0] count_reg, count_next;
    logic sclk_prev_reg, sclk_prev_next;
    logic cs_prev_reg, cs_prev_next;
    logic [8:0] regs_reg [sdt_pkg::NUM_REGS];
    logic [8:0] regs_next [sdt_pkg::NUM_REGS];
    logic [2:0] wr_idx;
    logic [6:0] wr_addr;
    logic wr_en;

    assign wr_addr = shift_reg[15:9];
    assign wr_en = ctl_cs_n && !cs_prev_reg && (count_reg == sdt_pkg::WORD_BITS);

    always_comb
    begin
        if (wr_addr == sdt_pkg::REG_TX_SOURCE_CONTROL)
            wr_idx = sdt_pkg::IDX_SRC;
        else if (wr_addr == sdt_pkg::REG_CHAN_STATUS_1)
            wr_idx = sdt_pkg::IDX_CS1;
        else if (wr_addr == sdt_pkg::REG_CHAN_STATUS_2)
            wr_idx = sdt_pkg::IDX_CS2;
        else if (wr_addr == sdt_pkg::REG_CHAN_STATUS_3)
            wr_idx = sdt_pkg::IDX_CS3;
        else if (wr_addr == sdt_pkg::REG_CHAN_STATUS_4)
            wr_idx = sdt_pkg::IDX_CS4;
        else if (wr_addr == sdt_pkg::REG_POWER_DOWN_TWO)
            wr_idx = sdt_pkg::IDX_PWR;
        else
            wr_idx = sdt_pkg::IDX_NONE;
    end

    always_comb
    begin
        sclk_prev_next = ctl_sclk;
        cs_prev_next = ctl_cs_n;
        shift_next = shift_reg;
        count_next = count_reg;
        if (ctl_cs_n)
            count_next = 5'h00;
        else if (ctl_sclk && !sclk_prev_reg)
        begin
            shift_next = {shift_reg[14:0], ctl_sdin};
            if (count_reg != sdt_pkg::WORD_BITS)
                count_next = count_reg + 5'h01;
        end
        for (int i = 0; i < sdt_pkg::NUM_REGS; i++)
        begin
            regs_next[i] = regs_reg[i];
            if (wr_en && (wr_idx == 3'(i)))
                regs_next[i] = shift_reg[8:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
            for (int i = 0; i < sdt_pkg::NUM_REGS; i++)
                regs_reg[i] <= sdt_pkg::RST_VALS[i];
        end
        else
        begin
            shift_reg <= shift_next;
            count_reg <= count_next;
            sclk_prev_reg <= sclk_prev_next;
            cs_prev_reg <= cs_prev_next;
            for (int i = 0; i < sdt_pkg::NUM_REGS; i++)
                regs_reg[i] <= regs_next[i];
        end
    end

    assign tx_source_control = regs_reg[sdt_pkg::IDX_SRC];
    assign chan_status_1 = regs_reg[sdt_pkg::IDX_CS1];
    assign chan_status_2 = regs_reg[sdt_pkg::IDX_CS2];
    assign chan_status_3 = regs_reg[sdt_pkg::IDX_CS3];
    assign chan_status_4 = regs_reg[sdt_pkg::IDX_CS4];
    assign power_down_two = regs_reg[sdt_pkg::IDX_PWR];
endmodule
`default_nettype wire

// >>> sdt_bmc_enc.sv
// bi-phase-mark line encoder, one half-cell per tick
`default_nettype none
module sdt_bmc_enc (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // half-cell stream
    input wire logic run,
    input wire logic tick,
    input wire logic pre_active,
    input wire logic [7:0] pre_pattern,
    input wire logic [2:0] pre_half_idx,
    input wire logic data_bit,
    input wire logic second_half,
    // encoded line level
    output logic line
);
    logic line_reg, line_next;
    logic pol_reg, pol_next;
    logic pol_eff;

    always_comb
    begin
        line_next = line_reg;
        pol_next = pol_reg;
        pol_eff = pol_reg;
        if (!run)
        begin
            line_next = 1'b0;
            pol_next = 1'b0;
        end
        else if (tick)
        begin
            if (pre_active)
            begin
                // preamble is a fixed pattern, flipped to follow the line level
                if (pre_half_idx == 3'h0)
                begin
                    pol_eff = line_reg;
                    pol_next = line_reg;
                end
                line_next = pre_pattern[3'h7 - pre_half_idx] ^ pol_eff;
            end
            else if (!second_half || data_bit)
                line_next = ~line_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            line_reg <= 1'b0;
            pol_reg <= 1'b0;
        end
        else
        begin
            line_reg <= line_next;
            pol_reg <= pol_next;
        end
    end

    assign line = line_reg;
endmodule
`default_nettype wire

// >>> sdt_framer_monitor.sv
// concurrent checks on the transmitter framer top-level ports
`default_nettype none
module sdt_framer_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // watched inputs
    input wire logic ctl_cs_n,
    input wire logic half_cell_tick,
    input wire logic spdif_in_mux,
    // watched outputs
    input wire logic sample_take,
    input wire logic tx_running,
    input wire logic serial_audio_out_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tick_cnt_reg, tick_cnt_next;
    logic seen_reg, seen_next;

    // half cells counted between two sample latches
    always_comb
    begin
        tick_cnt_next = tick_cnt_reg + {7'h00, half_cell_tick};
        if (sample_take)
            tick_cnt_next = {7'h00, half_cell_tick};
        seen_next = tx_running && (seen_reg || sample_take);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tick_cnt_reg <= 8'h00;
            seen_reg <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
            seen_reg <= seen_next;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_quiet;
        !tx_running [*4];
    endsequence
    sequence s_take_again;
        sample_take && seen_reg;
    endsequence

    a_reset_quiet: assert property ($fell(rst)
        |-> !serial_audio_out_pin && !tx_running && !sample_take)
        else $error("outputs not quiet after reset");
    a_take_pulse: assert property (sample_take |=> !sample_take)
        else $error("sample latch pulse longer than one cycle");
    a_take_after_tick: assert property (sample_take
        |-> $past(half_cell_tick) || $past(half_cell_tick, 2))
        else $error("sample latch not tied to a half-cell tick");
    a_take_running: assert property (sample_take |-> tx_running || $past(tx_running))
        else $error("sample latch while powered down");
    a_take_spacing: assert property (s_take_again |-> tick_cnt_reg == 8'h80)
        else $error("frame length in half cells is wrong");
    a_quiet_pin: assert property (s_quiet ##0 serial_audio_out_pin
        |-> $past(spdif_in_mux))
        else $error("line not static while powered down");
    a_pin_on_tick: assert property (tx_running && $changed(serial_audio_out_pin)
        |-> $past(half_cell_tick, 2) || serial_audio_out_pin == $past(spdif_in_mux))
        else $error("line moved away from a half-cell boundary");
    a_run_after_write: assert property ($changed(tx_running)
        |-> $past(ctl_cs_n) && $past(ctl_cs_n, 2) && !$past(ctl_cs_n, 3))
        else $error("run state changed without a control write");
endmodule
`default_nettype wire

// >>> sdt_rx_model.sv
// receiving equipment model: decodes the bi-phase-mark line into sub-frames
`default_nettype none
module sdt_rx_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // line and half-cell timing
    input wire logic half_cell_tick,
    input wire logic line,
    // decoded sub-frame: kind 0 block start, 1 first, 2 second
    output logic sf_valid,
    output logic [1:0] sf_kind,
    output logic [31:4] sf_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] tick_d;
    logic [63:0] halves, h;
    logic [6:0] cnt;
    logic [1:0] kind;

    function automatic logic is_pre(input logic [7:0] v, input logic [7:0] p);
        return (v == p) || (v == ~p);
    endfunction

    // the line is read three cycles after each tick, where it has settled
    always @(posedge clock)
    begin
        tick_d <= {tick_d[1:0], half_cell_tick};
        sf_valid <= 1'b0;
        if (rst)
        begin
            tick_d <= 3'h0;
            cnt <= 7'h7F;
        end
        else if (tick_d[2])
        begin
            h = {halves[62:0], line};
            halves <= h;
            if (is_pre(h[7:0], sdt_pkg::PRE_BLOCK))
            begin
                cnt <= 7'h00;
                kind <= 2'h0;
            end
            else if (is_pre(h[7:0], sdt_pkg::PRE_FIRST) || is_pre(h[7:0], sdt_pkg::PRE_SECOND))
            begin
                cnt <= 7'h00;
                kind <= is_pre(h[7:0], sdt_pkg::PRE_FIRST) ? 2'h1 : 2'h2;
            end
            // a cell without a transition at its start loses lock
            else if (cnt < 7'h38 && !cnt[0] && h[0] == h[1])
                cnt <= 7'h7F;
            else if (cnt != 7'h7F)
                cnt <= cnt + 7'h01;
            if (cnt == 7'h37)
            begin
                sf_valid <= 1'b1;
                sf_kind <= kind;
                for (int k = 4; k < 32; k++)
                    sf_bits[k] <= h[2 * (31 - k) + 1] ^ h[2 * (31 - k)];
            end
        end
    end
endmodule
`default_nettype wire

// >>> sdt_framer_test.sv
// testbench for the transmitter framer: control writes, frame decode, checks
`default_nettype none
module sdt_framer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, ctl_cs_n, ctl_sclk, ctl_sdin, tick, spdif_in_mux;
    logic sample_take, tx_running, pin, sf_valid, chk_en;
    logic [23:0] smp [8];
    logic [1:0] rx_v, rx_u, rx_c, sf_kind;
    logic [31:4] sf_bits;
    logic [8:0] sh_src, sh_cs1, sh_cs2, sh_cs3, sh_cs4, sfc;
    int n_sf, error_cnt, n_compared;

    sdt_framer sdt_framer_i (
        .clock(clock), .rst(rst), .ctl_cs_n(ctl_cs_n), .ctl_sclk(ctl_sclk), .ctl_sdin(ctl_sdin),
        .half_cell_tick(tick), .rx_sample_left(smp[0]), .rx_sample_right(smp[1]),
        .adc_sample_left(smp[2]), .adc_sample_right(smp[3]), .aif2_sample_left(smp[4]),
        .aif2_sample_right(smp[5]), .aif1_sample_left(smp[6]), .aif1_sample_right(smp[7]),
        .rx_validity_left(rx_v[0]), .rx_validity_right(rx_v[1]), .rx_user_left(rx_u[0]),
        .rx_user_right(rx_u[1]), .rx_chan_status_left(rx_c[0]), .rx_chan_status_right(rx_c[1]),
        .spdif_in_mux(spdif_in_mux), .sample_take(sample_take), .tx_running(tx_running),
        .serial_audio_out_pin(pin)
    );
    sdt_rx_model sdt_rx_model_i (
        .clock(clock), .rst(rst), .half_cell_tick(tick), .line(pin),
        .sf_valid(sf_valid), .sf_kind(sf_kind), .sf_bits(sf_bits)
    );

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // expected sub-frame n of a block: kind, parity, status, user, validity, sample
    function automatic logic [29:0] exp_sf(input logic [8:0] n);
        logic r;
        logic [1:0] s, code;
        logic [3:0] chn;
        logic [39:0] cs;
        logic v, u, c;
        r = n[0];
        s = sh_src[1:0];
        code = r ? sh_cs3[7:6] : sh_cs3[5:4];
        chn = (code == 2'h1) ? 4'h1 : ((code == 2'h2) ? 4'h2 : 4'h0);
        cs = {10'h000, sh_cs4[5:0], chn, sh_cs3[3:0], sh_cs2[7:0], sh_cs1[7:0]};
        v = (s == 2'h0) ? rx_v[r] : 1'b0;
        u = (s == 2'h0) ? rx_u[r] : 1'b0;
        c = (n[8:1] < 8'h28) ? cs[n[8:1]] : 1'b0;
        if (s == 2'h0 && !sh_src[2])
            c = rx_c[r];
        return {(n == 9'h000) ? 2'h0 : (r ? 2'h2 : 2'h1), ^{c, u, v, smp[{s, r}]}, c, u, v,
            smp[{s, r}]};
    endfunction

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        logic [15:0] w;
        w = {a, d};
        @(posedge clock);
        ctl_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clock);
            ctl_sclk <= 1'b0;
            ctl_sdin <= w[i];
            @(posedge clock);
            ctl_sclk <= 1'b1;
        end
        @(posedge clock);
        ctl_sclk <= 1'b0;
        @(posedge clock);
        ctl_cs_n <= 1'b1;
        repeat (4) @(posedge clock);
        case (a)
            sdt_pkg::REG_TX_SOURCE_CONTROL: sh_src = d;
            sdt_pkg::REG_CHAN_STATUS_1: sh_cs1 = d;
            sdt_pkg::REG_CHAN_STATUS_2: sh_cs2 = d;
            sdt_pkg::REG_CHAN_STATUS_3: sh_cs3 = d;
            sdt_pkg::REG_CHAN_STATUS_4: sh_cs4 = d;
            default: ;
        endcase
    endtask

    task automatic wait_sf(input int n);
        int target;
        int guard;
        target = n_sf + n;
        guard = 0;
        while (n_sf < target && guard < n * 200)
        begin
            @(posedge clock);
            guard++;
        end
        cmp({31'h0, n_sf >= target}, 32'h1);
    endtask

    // every decoded sub-frame is judged while checking is on
    always @(posedge clock)
    begin
        if (!tx_running)
            sfc <= 9'h000;
        else if (sf_valid)
        begin
            if (chk_en)
                cmp({2'h0, sf_kind, sf_bits},
                    {2'h0, exp_sf(sfc)});
            sfc <= (sfc == 9'h17F) ? 9'h000 : sfc + 9'h001;
            n_sf++;
        end
    end

    // powered down: static line, nothing running
    task automatic t_idle();
        logic seen;
        seen = 1'b0;
        repeat (300)
        begin
            @(posedge clock);
            seen = seen | pin;
        end
        cmp({31'h0, seen}, 32'h0);
        cmp({31'h0, tx_running}, 32'h0);
    endtask

    // status block over one whole block and four sub-frames from the adc source
    task automatic t_block();
        wr(sdt_pkg::REG_CHAN_STATUS_1, 9'h005);
        wr(sdt_pkg::REG_CHAN_STATUS_2, 9'h0A3);
        wr(sdt_pkg::REG_CHAN_STATUS_3, 9'h093);
        wr(sdt_pkg::REG_TX_SOURCE_CONTROL, {7'h00, sdt_pkg::SRC_ADC});
        wr(7'h73, 9'h000);
        cmp({31'h0, tx_running}, 32'h0);
        chk_en <= 1'b1;
        wr(sdt_pkg::REG_POWER_DOWN_TWO, 9'h000);
        cmp({31'h0, tx_running}, 32'h1);
        wait_sf(388);
    endtask

    // rx, aif2 and aif1 source codes, received data with and without status override
    task automatic t_sources();
        logic [8:0] codes [4];
        codes = '{9'h000, 9'h004, 9'h002, 9'h003};
        foreach (codes[i])
        begin
            chk_en <= 1'b0;
            wr(sdt_pkg::REG_TX_SOURCE_CONTROL, codes[i]);
            wait_sf(3);
            chk_en <= 1'b1;
            wait_sf(6);
        end
    endtask

    // through mode while down, then a restart at block start
    task automatic t_through();
        logic [8:0] v;
        v = 9'h1B5;
        chk_en <= 1'b0;
        wr(sdt_pkg::REG_POWER_DOWN_TWO, 9'h010);
        wr(sdt_pkg::REG_TX_SOURCE_CONTROL, 9'h008);
        for (int i = 0; i < 9; i++)
        begin
            spdif_in_mux <= v[i];
            repeat (2) @(posedge clock);
            cmp({31'h0, pin}, {31'h0, v[i]});
        end
        wr(sdt_pkg::REG_TX_SOURCE_CONTROL, 9'h000);
        t_idle();
        spdif_in_mux <= 1'b0;
        chk_en <= 1'b1;
        wr(sdt_pkg::REG_POWER_DOWN_TWO, 9'h000);
        wait_sf(6);
    endtask

    always @(posedge clock)
        tick <= rst ? 1'b0 : !tick;

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial
    begin
        repeat (90000) @(posedge clock);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        rst = 1'b1;
        {ctl_cs_n, ctl_sclk, ctl_sdin, tick, spdif_in_mux, chk_en} = 6'h20;
        {rx_v, rx_u, rx_c} = 6'h25;
        for (int i = 0; i < 8; i++)
            smp[i] = 24'h9A5C31 ^ {8{3'(i)}};
        {sh_src, sh_cs1, sh_cs2, sh_cs3} = 36'h0;
        sh_cs4 = 9'h031;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_idle();
        t_block();
        t_sources();
        t_through();
        tally_and_finish();
    end
endmodule

bind sdt_framer sdt_framer_monitor sdt_framer_monitor_i (
    .clock(clock), .rst(rst), .ctl_cs_n(ctl_cs_n), .half_cell_tick(half_cell_tick),
    .spdif_in_mux(spdif_in_mux), .sample_take(sample_take), .tx_running(tx_running),
    .serial_audio_out_pin(serial_audio_out_pin)
);
`default_nettype wire
